// ==== rtl/diag_regs_pkg.sv ====
// shared constants and types for the lower-memory register bank
package diag_regs_pkg;

   // ---------------------------------------------------------------
   // register map (lower memory byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] THR_BASE = 8'h02;
   localparam logic [7:0] THR_LAST = 8'h39;
   localparam logic [7:0] UEE_BASE = 8'h3a;
   localparam logic [7:0] UEE_LAST = 8'h3b;
   localparam logic [7:0] SRAM_BASE = 8'h46;
   localparam logic [7:0] SRAM_LAST = 8'h4f;
   localparam logic [7:0] CTL_ADDR = 8'h6e;
   localparam logic [7:0] STS_ADDR = 8'h6f;
   localparam logic [7:0] SUPPLY_ADDR = 8'h74;

   localparam int THR_BYTES = 56;
   localparam int UEE_BYTES = 2;
   localparam int SRAM_BYTES = 10;
   localparam int CHANNELS = 7;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CTL_MON_BUSY = 0;
   localparam int CTL_LOS = 1;
   localparam int CTL_INT = 2;
   localparam int CTL_SOFT_PD = 3;
   localparam int CTL_PD_PIN = 4;
   localparam int CTL_MODULE_BUSY = 5;
   localparam int CTL_SOFT_DIS = 6;
   localparam int CTL_TX_DIS = 7;
   localparam int STS_RX_UNLOCK = 3;
   localparam int STS_RX_BUSY = 4;
   localparam int STS_TX_FAULT = 6;
   localparam int STS_TX_BUSY = 7;
   localparam int SUPPLY_LOW_BIT = 7;

   // ---------------------------------------------------------------
   // reset values and timing
   // ---------------------------------------------------------------
   // per channel: high alarm, low alarm, high warning, low warning
   localparam logic [63:0] THR_CHAN_RESET = 64'h0000_ffff_0000_ffff;
   localparam logic [7:0] UEE_RESET = 8'h00;
   localparam logic [7:0] SRAM_RESET = 8'h00;
   localparam int POWERUP_CYCLES_DEF = 16;
   localparam logic [6:0] DEV_ADDR_DEF = 7'h51;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_ADDR = 4'h1,
      S_A_ACK = 4'h3,
      S_PTR = 4'h2,
      S_P_ACK = 4'h6,
      S_WR = 4'h7,
      S_W_ACK = 4'h5,
      S_RD = 4'h4,
      S_M_ACK = 4'hc
   } ser_state_t;

   typedef struct packed {
      logic signal_loss;
      logic int_level;
      logic pd_pin;
      logic module_not_ready;
      logic tx_disable;
      logic rx_recovery_unlocked;
      logic rx_not_ready;
      logic tx_fault;
      logic tx_not_ready;
      logic supply_below_trip;
      logic scl;
      logic sda;
   } pins_t;

   typedef struct packed {
      ser_state_t st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic rw;
      logic ack;
      logic scl_q;
      logic sda_q;
      logic [THR_BYTES-1:0][7:0] thr;
      logic [UEE_BYTES-1:0][7:0] uee;
      logic [SRAM_BYTES-1:0][7:0] sram;
      logic soft_pd;
      logic soft_dis;
      logic [15:0] pu_cnt;
      logic mon_busy;
      logic sda_oe_b;
      logic pd_out;
      logic rst_pulse;
      logic bias_off;
      logic mod_off;
   } bank_state_t;

   localparam bank_state_t BANK_RESET = '{
      st: S_IDLE,
      cnt: 4'h0,
      sh: 8'h00,
      ptr: 8'h00,
      rw: 1'b0,
      ack: 1'b0,
      scl_q: 1'b1,
      sda_q: 1'b1,
      thr: {CHANNELS{THR_CHAN_RESET}},
      uee: {UEE_BYTES{UEE_RESET}},
      sram: {SRAM_BYTES{SRAM_RESET}},
      soft_pd: 1'b0,
      soft_dis: 1'b0,
      pu_cnt: 16'h0000,
      mon_busy: 1'b1,
      sda_oe_b: 1'b1,
      pd_out: 1'b0,
      rst_pulse: 1'b0,
      bias_off: 1'b0,
      mod_off: 1'b0
   };

endpackage

// ==== rtl/pin_sync.sv ====
// two-flop synchroniser for a vector of asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_r;

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_r <= '0;
         q <= '0;
      end
      else
      begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule

`default_nettype wire

// ==== rtl/diag_lower_memory_regs.sv ====
// lower-memory register bank behind the two-wire serial port
`timescale 1ns/1ps
`default_nettype none

//
// Overview of operation
// - 16-bit thresholds, writes need module access
// - high limits reset FFFF, low limits 0000
// - two user_eeprom_bytes bytes, open access, zero
// - control/status byte shows live flags plus controls
// - monitor data not ready until power-up done
// - status bit follows receive signal loss
// - status bit mirrors interrupt pin level
// - soft power-down bit, toggle resets, maskable
// - bit 4 reports power-down/reset pin
// - bit 5 reports module-not-ready pin
// - soft-disable shuts bias and modulation currents
// - soft-disable gated by external mask bit
// - status bit follows transmit-disable pin
// - status bit 3: receive recovery unlocked
// - status bit 4: receive path not ready
// - status bit 6: laser safety fault
// - status bit 7: transmit not ready
// - supply flag bit 7 high below trip
module diag_lower_memory_regs
   import diag_regs_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF,
   parameter int POWERUP_CYCLES = POWERUP_CYCLES_DEF
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // asynchronous pins, serial bus lines included
   input wire diag_regs_pkg::pins_t pins,
   // serial data drive, pulled low while sda_oe_b is low
   output logic sda_o,
   output logic sda_oe_b,
   // access level and masks from configuration logic
   input wire logic module_access,
   input wire logic soft_power_down_mask,
   input wire logic soft_disable_mask,
   // controls to the rest of the device
   output logic power_down,
   output logic device_reset_pulse,
   output logic bias_set_current_off,
   output logic modulation_set_current_off
);

   import diag_regs_pkg::*;

   // ---------------------------------------------------------------
   // pin synchronisation
   // ---------------------------------------------------------------
   pins_t p;

   pin_sync #(
      .W($bits(pins_t))
   ) u_pin_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d(pins),
      .q(p)
   );

   bank_state_t r;
   bank_state_t n;

   // ---------------------------------------------------------------
   // read data mux
   // ---------------------------------------------------------------
   logic [7:0] rd_data;
   logic [7:0] off;

   always_comb
   begin
      rd_data = 8'h00;
      off = 8'h00;
      if (r.ptr >= THR_BASE && r.ptr <= THR_LAST)
      begin
         off = r.ptr - THR_BASE;
         rd_data = r.thr[off[5:0]];
      end
      else if (r.ptr >= UEE_BASE && r.ptr <= UEE_LAST)
      begin
         off = r.ptr - UEE_BASE;
         rd_data = r.uee[off[0]];
      end
      else if (r.ptr >= SRAM_BASE && r.ptr <= SRAM_LAST)
      begin
         off = r.ptr - SRAM_BASE;
         rd_data = r.sram[off[3:0]];
      end
      else if (r.ptr == CTL_ADDR)
      begin
         // live levels, no latching
         rd_data[CTL_MON_BUSY] = r.mon_busy;
         rd_data[CTL_LOS] = p.signal_loss;
         rd_data[CTL_INT] = p.int_level;
         rd_data[CTL_SOFT_PD] = r.soft_pd;
         rd_data[CTL_PD_PIN] = p.pd_pin;
         rd_data[CTL_MODULE_BUSY] = p.module_not_ready;
         rd_data[CTL_SOFT_DIS] = r.soft_dis;
         rd_data[CTL_TX_DIS] = p.tx_disable;
      end
      else if (r.ptr == STS_ADDR)
      begin
         // reserved bits stay zero
         rd_data[STS_RX_UNLOCK] = p.rx_recovery_unlocked;
         rd_data[STS_RX_BUSY] = p.rx_not_ready;
         rd_data[STS_TX_FAULT] = p.tx_fault;
         rd_data[STS_TX_BUSY] = p.tx_not_ready;
      end
      else if (r.ptr == SUPPLY_ADDR)
      begin
         rd_data[SUPPLY_LOW_BIT] = p.supply_below_trip;
      end
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   logic start_c;
   logic stop_c;
   logic rise_c;
   logic fall_c;
   logic [7:0] woff;

   always_comb
   begin
      n = r;
      woff = 8'h00;
      start_c = r.scl_q & p.scl & r.sda_q & ~p.sda;
      stop_c = r.scl_q & p.scl & ~r.sda_q & p.sda;
      rise_c = ~r.scl_q & p.scl;
      fall_c = r.scl_q & ~p.scl;
      n.scl_q = p.scl;
      n.sda_q = p.sda;
      n.rst_pulse = 1'b0;

      // power-up settle before monitor results are valid
      if (r.mon_busy)
      begin
         if (r.pu_cnt == 16'(POWERUP_CYCLES - 1))
            n.mon_busy = 1'b0;
         else
            n.pu_cnt = r.pu_cnt + 16'h0001;
      end

      n.pd_out = r.soft_pd & ~soft_power_down_mask;
      n.bias_off = r.soft_dis & ~soft_disable_mask;
      n.mod_off = r.soft_dis & ~soft_disable_mask;

      if (start_c)
      begin
         // repeated start keeps the pointer
         n.st = S_ADDR;
         n.cnt = 4'h0;
         n.sda_oe_b = 1'b1;
      end
      else if (stop_c)
      begin
         n.st = S_IDLE;
         n.sda_oe_b = 1'b1;
      end
      else if (rise_c)
      begin
         unique case (r.st)
            S_ADDR, S_PTR, S_WR:
            begin
               n.sh = {r.sh[6:0], p.sda};
               n.cnt = r.cnt + 4'h1;
            end
            S_M_ACK:
               n.ack = ~p.sda;
            default:
               n.ack = r.ack;
         endcase
      end
      else if (fall_c)
      begin
         unique case (r.st)
            S_ADDR:
            begin
               if (r.cnt == 4'h8)
               begin
                  if (r.sh[7:1] == DEV_ADDR)
                  begin
                     n.rw = r.sh[0];
                     n.sda_oe_b = 1'b0;
                     n.st = S_A_ACK;
                  end
                  else
                     n.st = S_IDLE;
               end
            end
            S_A_ACK:
            begin
               n.cnt = 4'h0;
               if (r.rw)
               begin
                  n.sh = rd_data;
                  n.ptr = r.ptr + 8'h01;
                  n.sda_oe_b = rd_data[7];
                  n.st = S_RD;
               end
               else
               begin
                  n.sda_oe_b = 1'b1;
                  n.st = S_PTR;
               end
            end
            S_PTR:
            begin
               if (r.cnt == 4'h8)
               begin
                  n.ptr = r.sh;
                  n.sda_oe_b = 1'b0;
                  n.st = S_P_ACK;
               end
            end
            S_P_ACK, S_W_ACK:
            begin
               n.sda_oe_b = 1'b1;
               n.cnt = 4'h0;
               n.st = S_WR;
            end
            S_WR:
            begin
               if (r.cnt == 4'h8)
               begin
                  if (r.ptr >= THR_BASE && r.ptr <= THR_LAST)
                  begin
                     woff = r.ptr - THR_BASE;
                     if (module_access)
                        n.thr[woff[5:0]] = r.sh;
                  end
                  else if (r.ptr >= UEE_BASE && r.ptr <= UEE_LAST)
                  begin
                     woff = r.ptr - UEE_BASE;
                     n.uee[woff[0]] = r.sh;
                  end
                  else if (r.ptr >= SRAM_BASE && r.ptr <= SRAM_LAST)
                  begin
                     woff = r.ptr - SRAM_BASE;
                     n.sram[woff[3:0]] = r.sh;
                  end
                  else if (r.ptr == CTL_ADDR)
                  begin
                     // only the two control bits take writes
                     n.soft_pd = r.sh[CTL_SOFT_PD];
                     n.soft_dis = r.sh[CTL_SOFT_DIS];
                     // release of the bit after setting it resets the device unless soft_power_down_mask is set
                     n.rst_pulse = r.soft_pd & ~r.sh[CTL_SOFT_PD]
                        & ~soft_power_down_mask;
                  end
                  // status and supply bytes: write dropped
                  n.ptr = r.ptr + 8'h01;
                  n.sda_oe_b = 1'b0;
                  n.st = S_W_ACK;
               end
            end
            S_RD:
            begin
               n.sh = {r.sh[6:0], 1'b0};
               n.cnt = r.cnt + 4'h1;
               if (r.cnt == 4'h7)
               begin
                  n.sda_oe_b = 1'b1;
                  n.st = S_M_ACK;
               end
               else
                  n.sda_oe_b = r.sh[6];
            end
            S_M_ACK:
            begin
               if (r.ack)
               begin
                  n.sh = rd_data;
                  n.ptr = r.ptr + 8'h01;
                  n.cnt = 4'h0;
                  n.sda_oe_b = rd_data[7];
                  n.st = S_RD;
               end
               else
               begin
                  n.sda_oe_b = 1'b1;
                  n.st = S_IDLE;
               end
            end
            default:
               n.st = S_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   // nonvolatile bytes are modelled by their factory values at reset
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         r <= BANK_RESET;
      else
         r <= n;
   end

   assign sda_o = 1'b0;
   assign sda_oe_b = r.sda_oe_b;
   assign power_down = r.pd_out;
   assign device_reset_pulse = r.rst_pulse;
   assign bias_set_current_off = r.bias_off;
   assign modulation_set_current_off = r.mod_off;

endmodule

`default_nettype wire

// ==== bench/diag_lower_memory_regs_assertions.sv ====
// concurrent checks on the control outputs of the register bank
`timescale 1ns/1ps
`default_nettype none
module diag_lower_memory_regs_checker
   import diag_regs_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // inputs
   input wire diag_regs_pkg::pins_t pins,
   input wire logic module_access,
   input wire logic soft_power_down_mask,
   input wire logic soft_disable_mask,
   // outputs
   input wire logic sda_o,
   input wire logic sda_oe_b,
   input wire logic power_down,
   input wire logic device_reset_pulse,
   input wire logic bias_set_current_off,
   input wire logic modulation_set_current_off
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   chk_currents_paired:
      assert property (bias_set_current_off == modulation_set_current_off)
      else $error("shutdown outputs differ");
   chk_disable_masked:
      assert property (soft_disable_mask |=> !bias_set_current_off)
      else $error("shutdown while masked");
   chk_disable_rise:
      assert property ($rose(bias_set_current_off) |-> !$past(soft_disable_mask))
      else $error("shutdown rose under mask");
   // a clear can only come from a bus write, which acknowledges at once
   chk_disable_clear:
      assert property ($fell(bias_set_current_off) && !$past(soft_disable_mask)
         |-> ##[0:6] !sda_oe_b)
      else $error("shutdown cleared without a write");
   chk_pd_masked:
      assert property (soft_power_down_mask |=> !power_down)
      else $error("power down while masked");
   chk_pulse_single:
      assert property (device_reset_pulse |=> !device_reset_pulse)
      else $error("reset pulse too long");
   chk_pulse_unmasked:
      assert property (device_reset_pulse |-> !$past(soft_power_down_mask))
      else $error("reset pulse under mask");
   chk_pulse_ends_pd:
      assert property (device_reset_pulse |=> !power_down && $past(power_down, 2))
      else $error("reset pulse without power down toggle");
endmodule
`default_nettype wire

// ==== bench/host_model.sv ====
// two-wire bus host driving clock and data toward the register bank
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // clock
   input wire logic clk,
   // bus lines
   input wire logic sda_in,
   output logic scl,
   output logic sda
);
   // phases of 4 and 6 clocks meet the 4-clock minimum
   initial
   begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda <= b;
      hold(4);
      scl <= 1'b1;
      hold(6);
      r = sda_in;
      scl <= 1'b0;
      hold(4);
   endtask
   task automatic start();
      sda <= 1'b1;
      hold(4);
      scl <= 1'b1;
      hold(6);
      sda <= 1'b0;
      hold(6);
      scl <= 1'b0;
      hold(4);
   endtask
   task automatic stop();
      sda <= 1'b0;
      hold(4);
      scl <= 1'b1;
      hold(6);
      sda <= 1'b1;
      hold(6);
   endtask
   // m is the level sent in the ninth slot, a is what the line showed there
   task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q,
      output logic a);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(m, a);
   endtask
endmodule
`default_nettype wire

// ==== bench/diag_lower_memory_regs_tb.sv ====
// self-checking bench for the lower-memory register bank
`timescale 1ns/1ps
`default_nettype none
module diag_lower_memory_regs_tb;
   import diag_regs_pkg::*;
   localparam int PU = 2000;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [9:0] lv = 10'h000;
   logic module_access = 1'b0;
   logic soft_power_down_mask = 1'b0;
   logic soft_disable_mask = 1'b0;
   logic scl, sda_h, sda_w, sda_o, sda_oe_b, power_down, pulse, bias_off, mod_off;
   pins_t pins_in;
   int failures = 0;
   int tests_run = 0;
   int pulses = 0;
   always #5 clk = ~clk;
   // pull-up on the data line: low when either side pulls
   assign sda_w = sda_h & (sda_oe_b | sda_o);
   always_comb pins_in = {lv, scl, sda_w};
   always @(posedge clk) if (pulse === 1'b1) pulses <= pulses + 1;
   diag_lower_memory_regs #(.DEV_ADDR(DEV_ADDR_DEF), .POWERUP_CYCLES(PU))
   u_diag_lower_memory_regs (.clk(clk), .rst_b(rst_b), .pins(pins_in), .sda_o(sda_o),
      .sda_oe_b(sda_oe_b), .module_access(module_access),
      .soft_power_down_mask(soft_power_down_mask), .soft_disable_mask(soft_disable_mask),
      .power_down(power_down), .device_reset_pulse(pulse),
      .bias_set_current_off(bias_off), .modulation_set_current_off(mod_off));
   host_model u_host_model (.clk(clk), .sda_in(sda_w), .scl(scl), .sda(sda_h));
   // ------------------------------------------------------------
   // bus tasks and scenarios
   // ------------------------------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic put(input logic [7:0] d);
      logic [7:0] q;
      logic a;
      u_host_model.xfer(d, 1'b1, q, a);
      if (a !== 1'b0)
      begin
         failures++;
         $display("FAIL %0t no acknowledge for %h", $time, d);
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      u_host_model.start();
      put({DEV_ADDR_DEF, 1'b0});
      put(ad);
      put(d);
      u_host_model.stop();
   endtask
   task automatic rdc(input logic [7:0] ad, input logic [7:0] exp);
      logic [7:0] q;
      logic a;
      u_host_model.start();
      put({DEV_ADDR_DEF, 1'b0});
      put(ad);
      u_host_model.start();
      put({DEV_ADDR_DEF, 1'b1});
      u_host_model.xfer(8'hff, 1'b1, q, a);
      u_host_model.stop();
      check(q, exp);
   endtask
   task automatic t_factory();
      rdc(CTL_ADDR, 8'h01);
      repeat (PU) @(posedge clk);
      rdc(CTL_ADDR, 8'h00);
      for (int i = 0; i < 8; i++) rdc(8'(THR_BASE + i), i[1] ? 8'h00 : 8'hff);
      rdc(THR_LAST, 8'h00);
      rdc(UEE_BASE, 8'h00);
      rdc(SRAM_LAST, 8'h00);
   endtask
   task automatic t_access();
      wr(8'h0a, 8'h12);
      rdc(8'h0a, 8'hff);
      module_access <= 1'b1;
      wr(8'h0a, 8'h12);
      rdc(8'h0a, 8'h12);
      wr(UEE_LAST, 8'ha5);
      rdc(UEE_LAST, 8'ha5);
      wr(SRAM_BASE, 8'h5a);
      rdc(SRAM_BASE, 8'h5a);
      wr(8'h50, 8'hc3);
      rdc(8'h50, 8'h00);
   endtask
   task automatic t_status(input logic [9:0] p);
      lv <= p;
      repeat (4) @(posedge clk);
      rdc(CTL_ADDR, {p[5], 1'b0, p[6], p[7], 1'b0, p[8], p[9], 1'b0});
      rdc(STS_ADDR, {p[1], p[2], 1'b0, p[3], p[4], 3'b000});
      rdc(SUPPLY_ADDR, {p[0], 7'h00});
   endtask
   task automatic t_soft();
      int p0;
      wr(CTL_ADDR, 8'h48);
      rdc(CTL_ADDR, 8'h48);
      check({5'h00, power_down, bias_off, mod_off}, 8'h07);
      soft_disable_mask <= 1'b1;
      repeat (2) @(posedge clk);
      check({5'h00, power_down, bias_off, mod_off}, 8'h04);
      p0 = pulses;
      wr(CTL_ADDR, 8'h40);
      check(8'(pulses - p0), 8'h01);
      check({6'h00, power_down, bias_off}, 8'h00);
      soft_power_down_mask <= 1'b1;
      wr(CTL_ADDR, 8'h48);
      soft_disable_mask <= 1'b0;
      repeat (2) @(posedge clk);
      check({5'h00, power_down, bias_off, mod_off}, 8'h03);
      wr(CTL_ADDR, 8'h00);
      check(8'(pulses - p0), 8'h01);
      check({5'h00, power_down, bias_off, mod_off}, 8'h00);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      t_factory();
      t_access();
      t_status(10'h2aa);
      wr(STS_ADDR, 8'hff);
      wr(SUPPLY_ADDR, 8'hff);
      t_status(10'h155);
      lv <= 10'h000;
      t_soft();
      conclude();
   end
   initial
   begin
      repeat (100000) @(posedge clk);
      failures++;
      $display("FAIL %0t run timed out", $time);
      conclude();
   end
endmodule
bind diag_lower_memory_regs diag_lower_memory_regs_checker u_diag_lower_memory_regs_checker (
   .clk(clk), .rst_b(rst_b), .pins(pins), .module_access(module_access),
   .soft_power_down_mask(soft_power_down_mask), .soft_disable_mask(soft_disable_mask),
   .sda_o(sda_o), .sda_oe_b(sda_oe_b), .power_down(power_down),
   .device_reset_pulse(device_reset_pulse), .bias_set_current_off(bias_set_current_off),
   .modulation_set_current_off(modulation_set_current_off));
`default_nettype wire
